// [bench/tb_wake_frame_matcher.sv]
module tb_wake_frame_matcher;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic tq_valid = 1'b0;
   logic [7:0] tq_data = 8'h00;
   logic tq_clear = 1'b0;
   logic rx_for_station = 1'b1;
   logic asleep = 1'b1;
   logic addr_rep_en = 1'b1;
   logic [47:0] station_addr = 48'h5a4b3c2d1e0f;
   logic rx_valid, rx_sof, rx_eof, wake_event, repeat_hit, table_full;
   logic [7:0] rx_data;
   logic [wfm_pkg::NDESC-1:0] pattern_hit;
   int n_fail = 0;
   int cmp_count = 0;
   int rep_cnt = 0;
   logic [7:0] fa[$];
   logic [7:0] sq[$];
   logic [31:0] r0, r1, r2, r3;
   // ==========================================
   // clock, instances, repeat hit counter
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      rep_cnt <= rep_cnt + (repeat_hit === 1'b1);
   end
   wfm_matcher u_dut (.ref_clk, .sys_rst, .tq_valid, .tq_data, .tq_clear, .rx_valid, .rx_data,
      .rx_sof, .rx_eof, .rx_for_station, .asleep, .addr_rep_en, .station_addr, .wake_event,
      .pattern_hit, .repeat_hit, .table_full);
   wfm_rx_station u_rx (.ref_clk, .rx_valid, .rx_data, .rx_sof, .rx_eof);
   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic logic [31:0] ref_crc(input logic [7:0] f[$], input int sk[$], input int tk[$]);
      logic [31:0] c;
      int p;
      c = 32'hffffffff;
      p = 0;
      foreach (sk[k])
      begin
         p += sk[k];
         for (int j = 0; j < tk[k]; j++)
         begin
            c ^= {24'h000000, f[p]};
            repeat (8)
               c = (c >> 1) ^ (c[0] ? wfm_pkg::CRC_POLY : 32'h00000000);
            p++;
         end
      end
      return ~c;
   endfunction
   task automatic ld(input logic [7:0] b[$], input logic [31:0] r);
      b.push_back(8'h00);
      for (int i = 0; i < 4; i++)
         b.push_back(r[8*i +: 8]);
      foreach (b[i])
      begin
         @(posedge ref_clk);
         #1;
         tq_valid = 1'b1;
         tq_data = b[i];
      end
      @(posedge ref_clk);
      #1;
      tq_valid = 1'b0;
   endtask
   task automatic fr(input logic [7:0] f[$], input logic [3:0] e);
      u_rx.send(f);
      chk(pattern_hit, e);
      chk(wake_event, |e);
      @(posedge ref_clk);
      #1;
      chk(pattern_hit, 4'h0);
   endtask
   task automatic mk(input int nff, input int ncp);
      sq = {8'h11, 8'h22};
      repeat (nff)
         sq.push_back(8'hff);
      for (int k = 0; k < ncp * 6; k++)
         sq.push_back(station_addr[8*(k%6) +: 8]);
   endtask
   task automatic rp(input int e);
      int n;
      @(posedge ref_clk);
      #1;
      n = rep_cnt;
      u_rx.send(sq);
      @(posedge ref_clk);
      #1;
      chk(rep_cnt - n, e);
   endtask
   // ==========================================
   // scenarios
   task automatic s_pat();
      ld({8'h21, 8'h12}, r0);
      ld({8'hff, 8'h14, 8'h03, 8'h3f, 8'h10, 8'he0, 8'h0e}, r1);
      chk(table_full, 1'b0);
      fr(fa, 4'h3);
      sq = fa;
      sq[3] ^= 8'h5a;
      fr(sq, 4'h3);
      sq[4] ^= 8'h5a;
      fr(sq, 4'h2);
      fr(fa[0:7], 4'h1);
      fr(fa[0:4], 4'h0);
      $display("done pattern");
   endtask
   task automatic s_full();
      ld({8'h02}, r2);
      ld({8'hf0, 8'h04, 8'h01}, r3);
      @(posedge ref_clk);
      #1;
      chk(table_full, 1'b1);
      ld({8'h01}, 32'h00000000);
      fr(fa, 4'hf);
      fr({fa[0], fa[1], 8'h00}, 4'h4);
      tq_clear = 1'b1;
      @(posedge ref_clk);
      #1;
      tq_clear = 1'b0;
      chk(table_full, 1'b0);
      fr(fa, 4'h0);
      $display("done full");
   endtask
   task automatic s_rep();
      mk(6, 16);
      u_rx.send(sq);
      chk(repeat_hit, 1'b1);
      chk(wake_event, 1'b1);
      asleep = 1'b0;
      rp(0);
      asleep = 1'b1;
      rx_for_station = 1'b0;
      rp(0);
      rx_for_station = 1'b1;
      mk(5, 16);
      rp(0);
      mk(6, 15);
      sq.push_back(8'h33);
      rp(0);
      mk(6, 16);
      sq = {sq, sq, 8'h44};
      rp(1);
      $display("done repeat");
   endtask
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      for (int i = 0; i < 80; i++)
         fa.push_back(8'(i * 7 + 3));
      r0 = ref_crc(fa, {2, 1}, {1, 2});
      r1 = ref_crc(fa, {20, 3, 14, 0}, {3, 16, 0, 14});
      r2 = ref_crc(fa, {0}, {2});
      r3 = ref_crc(fa, {4, 0}, {0, 1});
      repeat (10) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      chk(wake_event | table_full | repeat_hit, 1'b0);
      s_pat();
      s_full();
      s_rep();
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      tally_and_finish();
   end
endmodule

// [bench/wfm_rx_station.sv]
module wfm_rx_station (
   input wire logic ref_clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_sof,
   output logic rx_eof
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // frame sender, data inverted when idle
   initial
   begin
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_data = 8'h00;
   end
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i])
      begin
         @(posedge ref_clk);
         #1;
         rx_valid = 1'b1;
         rx_data = f[i];
         rx_sof = (i == 0);
         rx_eof = (i == f.size() - 1);
      end
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_data = ~rx_data;
   endtask
endmodule

// [bench/wfm_sva.sv]
module wfm_sva (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic tq_clear,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_sof,
   input wire logic rx_eof,
   input wire logic rx_for_station,
   input wire logic asleep,
   input wire logic addr_rep_en,
   input wire logic [47:0] station_addr,
   input wire logic wake_event,
   input wire logic [wfm_pkg::NDESC-1:0] pattern_hit,
   input wire logic repeat_hit,
   input wire logic table_full
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] nb_r;
   logic [7:0] nb_nxt;
   // ==========================================
   // bytes since frame start, saturating
   always_comb
   begin
      nb_nxt = nb_r;
      if (rx_valid)
      begin
         nb_nxt = rx_sof ? 8'h01 : ((nb_r == 8'hff) ? nb_r : nb_r + 8'h01);
      end
   end
   always_ff @(posedge ref_clk)
   begin
      nb_r <= sys_rst ? 8'h00 : nb_nxt;
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================
   // properties
   property p_wake_or;
      wake_event == ((|pattern_hit) || repeat_hit);
   endproperty
   a_wake_or: assert property (p_wake_or) else $error("wake not or of hits");
   property p_rep_pulse;
      repeat_hit |=> !repeat_hit;
   endproperty
   a_rep_pulse: assert property (p_rep_pulse) else $error("repeat hit too long");
   property p_pat_eof;
      |pattern_hit |-> $past(rx_valid && rx_eof);
   endproperty
   a_pat_eof: assert property (p_pat_eof) else $error("pattern hit not after eof");
   property p_rep_mode;
      repeat_hit |-> $past(addr_rep_en && asleep && rx_for_station);
   endproperty
   a_rep_mode: assert property (p_rep_mode) else $error("repeat hit out of mode");
   property p_rep_last;
      repeat_hit |-> $past(rx_valid) && ($past(rx_data) == station_addr[47:40]);
   endproperty
   a_rep_last: assert property (p_rep_last) else $error("repeat hit not on last byte");
   property p_rep_len;
      repeat_hit |-> nb_r >= 8'h66;
   endproperty
   a_rep_len: assert property (p_rep_len) else $error("repeat hit too early");
   property p_full_hold;
      table_full && !tq_clear |=> table_full;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full dropped");
   property p_clear;
      tq_clear |=> !table_full;
   endproperty
   a_clear: assert property (p_clear) else $error("full after clear");
   c_pat: cover property (pattern_hit[0]);
   c_rep: cover property (repeat_hit);
   c_full: cover property ($rose(table_full));
endmodule

bind wfm_matcher wfm_sva u_sva (
   .ref_clk, .sys_rst, .tq_clear, .rx_valid, .rx_data, .rx_sof, .rx_eof,
   .rx_for_station, .asleep, .addr_rep_en, .station_addr, .wake_event,
   .pattern_hit, .repeat_hit, .table_full
);

// [rtl/wfm_matcher.sv]
// Functional notes
// - pattern descriptors arrive as bytes from the transmit queue load port.
// - each descriptor runs a crc over only its selected received bytes.
// - computed crc equal to stored crc raises a wake event.
// - false wakes from crc aliasing are accepted, no extra filtering.
// - descriptor is pairs, then end marker, then four crc bytes.
// - each pair first skips skip_length bytes from the previous group end.
// - then take_length bytes are fed into the crc.
// - four bytes after the end marker are the reference crc.
// - next descriptor starts right after the previous crc bytes.
// - when enabled and asleep, frames for this station are scanned.
// - sync run then sixteen copies of the station address, 96 bytes.
// - sync run is six consecutive 0xff bytes.
// - sequence is found at any byte position in the frame.
// - crc is the 32-bit ethernet fcs crc.
// - reference crc stored least significant byte first.
// - pair low nibble take, high nibble skip; 0xf means extended next byte.
// - both nibbles 0xf: extended skip byte then extended take byte.
// - pair byte 0x00 is the end marker.
module wfm_matcher (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic tq_valid,
   input wire logic [7:0] tq_data,
   input wire logic tq_clear,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_sof,
   input wire logic rx_eof,
   input wire logic rx_for_station,
   input wire logic asleep,
   input wire logic addr_rep_en,
   input wire logic [47:0] station_addr,
   output logic wake_event,
   output logic [wfm_pkg::NDESC-1:0] pattern_hit,
   output logic repeat_hit,
   output logic table_full
);

   // ==========================================
   // skip/take walk helper
   function automatic logic [12:0] lane_norm(input logic [3:0] seg, input logic tk, input logic [7:0] rem,
                                             input wfm_pkg::wfm_row_t sk, input wfm_pkg::wfm_row_t tl,
                                             input logic [3:0] ns);
      logic [3:0] s;
      logic t;
      logic [7:0] r;
      s = seg;
      t = tk;
      r = rem;
      for (int k = 0; k < 2 * wfm_pkg::NSEG + 1; k++)
      begin
         if (s < ns && r == 8'h00)
         begin
            if (!t)
            begin
               t = 1'b1;
               r = tl[s[wfm_pkg::SIDX_W-1:0]];
            end
            else
            begin
               t = 1'b0;
               s = s + 4'h1;
               r = (s < ns) ? sk[s[wfm_pkg::SIDX_W-1:0]] : 8'h00;
            end
         end
      end
      return {s, t, r};
   endfunction

   // ==========================================
   // descriptor loader
   wfm_pkg::wfm_ld_state_t ld_st_r, ld_st_nxt;
   logic [wfm_pkg::DESC_W-1:0] ld_desc_r, ld_desc_nxt;
   logic [wfm_pkg::SEG_W-1:0] ld_seg_r, ld_seg_nxt;
   logic [7:0] ld_skip_r, ld_skip_nxt;
   logic ld_takef_r, ld_takef_nxt;
   logic ld_ovf_r, ld_ovf_nxt;
   logic [1:0] ld_crcb_r, ld_crcb_nxt;
   wfm_pkg::wfm_row_t skip_tab_r [wfm_pkg::NDESC];
   wfm_pkg::wfm_row_t skip_tab_nxt [wfm_pkg::NDESC];
   wfm_pkg::wfm_row_t take_tab_r [wfm_pkg::NDESC];
   wfm_pkg::wfm_row_t take_tab_nxt [wfm_pkg::NDESC];
   logic [wfm_pkg::SEG_W-1:0] nseg_r [wfm_pkg::NDESC];
   logic [wfm_pkg::SEG_W-1:0] nseg_nxt [wfm_pkg::NDESC];
   logic [31:0] ref_crc_r [wfm_pkg::NDESC];
   logic [31:0] ref_crc_nxt [wfm_pkg::NDESC];
   logic [wfm_pkg::NDESC-1:0] dvalid_r, dvalid_nxt;
   logic table_full_r, table_full_nxt;
   logic st_en;
   logic [7:0] st_skip;
   logic [7:0] st_take;

   always_comb
   begin
      ld_st_nxt = ld_st_r;
      ld_desc_nxt = ld_desc_r;
      ld_seg_nxt = ld_seg_r;
      ld_skip_nxt = ld_skip_r;
      ld_takef_nxt = ld_takef_r;
      ld_ovf_nxt = ld_ovf_r;
      ld_crcb_nxt = ld_crcb_r;
      skip_tab_nxt = skip_tab_r;
      take_tab_nxt = take_tab_r;
      nseg_nxt = nseg_r;
      ref_crc_nxt = ref_crc_r;
      dvalid_nxt = dvalid_r;
      st_en = 1'b0;
      st_skip = 8'h00;
      st_take = 8'h00;
      if (tq_clear)
      begin
         ld_st_nxt = wfm_pkg::WFM_LD_PAIR;
         ld_desc_nxt = '0;
         ld_seg_nxt = '0;
         ld_ovf_nxt = 1'b0;
         ld_crcb_nxt = 2'h0;
         dvalid_nxt = '0;
      end
      else if (tq_valid)
      begin
         unique case (ld_st_r)
            wfm_pkg::WFM_LD_PAIR:
            begin
               if (tq_data == wfm_pkg::TERM_BYTE)
               begin
                  ld_st_nxt = wfm_pkg::WFM_LD_CRC;
                  ld_crcb_nxt = 2'h0;
               end
               else if (tq_data[7:4] == wfm_pkg::EXT_NIB)
               begin
                  ld_st_nxt = wfm_pkg::WFM_LD_EXT_SKIP;
                  ld_takef_nxt = (tq_data[3:0] == wfm_pkg::EXT_NIB);
                  ld_skip_nxt = {4'h0, tq_data[3:0]};
               end
               else if (tq_data[3:0] == wfm_pkg::EXT_NIB)
               begin
                  ld_st_nxt = wfm_pkg::WFM_LD_EXT_TAKE;
                  ld_skip_nxt = {4'h0, tq_data[7:4]};
               end
               else
               begin
                  st_en = 1'b1;
                  st_skip = {4'h0, tq_data[7:4]};
                  st_take = {4'h0, tq_data[3:0]};
               end
            end
            wfm_pkg::WFM_LD_EXT_SKIP:
            begin
               if (ld_takef_r)
               begin
                  ld_skip_nxt = tq_data;
                  ld_st_nxt = wfm_pkg::WFM_LD_EXT_TAKE;
               end
               else
               begin
                  st_en = 1'b1;
                  st_skip = tq_data;
                  st_take = ld_skip_r;
                  ld_st_nxt = wfm_pkg::WFM_LD_PAIR;
               end
            end
            wfm_pkg::WFM_LD_EXT_TAKE:
            begin
               st_en = 1'b1;
               st_skip = ld_skip_r;
               st_take = tq_data;
               ld_st_nxt = wfm_pkg::WFM_LD_PAIR;
            end
            wfm_pkg::WFM_LD_CRC:
            begin
               ref_crc_nxt[ld_desc_r[1:0]][8 * ld_crcb_r +: 8] = tq_data;
               ld_crcb_nxt = ld_crcb_r + 2'h1;
               if (ld_crcb_r == wfm_pkg::CRC_LAST_BYTE)
               begin
                  dvalid_nxt[ld_desc_r[1:0]] = ~ld_ovf_r;
                  nseg_nxt[ld_desc_r[1:0]] = ld_seg_r;
                  ld_desc_nxt = ld_desc_r + 3'h1;
                  ld_seg_nxt = '0;
                  ld_ovf_nxt = 1'b0;
                  ld_st_nxt = (ld_desc_r + 3'h1 == wfm_pkg::NDESC_L) ? wfm_pkg::WFM_LD_FULL : wfm_pkg::WFM_LD_PAIR;
               end
            end
            wfm_pkg::WFM_LD_FULL:
            begin
               ld_st_nxt = wfm_pkg::WFM_LD_FULL;
            end
         endcase
      end
      if (st_en)
      begin
         if (ld_seg_r == wfm_pkg::NSEG_L)
         begin
            ld_ovf_nxt = 1'b1;
         end
         else
         begin
            skip_tab_nxt[ld_desc_r[1:0]][ld_seg_r[wfm_pkg::SIDX_W-1:0]] = st_skip;
            take_tab_nxt[ld_desc_r[1:0]][ld_seg_r[wfm_pkg::SIDX_W-1:0]] = st_take;
            ld_seg_nxt = ld_seg_r + 4'h1;
         end
      end
      table_full_nxt = (ld_st_nxt == wfm_pkg::WFM_LD_FULL);
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ld_st_r <= wfm_pkg::WFM_LD_PAIR;
         ld_desc_r <= '0;
         ld_seg_r <= '0;
         ld_skip_r <= 8'h00;
         ld_takef_r <= 1'b0;
         ld_ovf_r <= 1'b0;
         ld_crcb_r <= 2'h0;
         skip_tab_r <= '{default: '0};
         take_tab_r <= '{default: '0};
         nseg_r <= '{default: '0};
         ref_crc_r <= '{default: '0};
         dvalid_r <= '0;
         table_full_r <= 1'b0;
      end
      else
      begin
         ld_st_r <= ld_st_nxt;
         ld_desc_r <= ld_desc_nxt;
         ld_seg_r <= ld_seg_nxt;
         ld_skip_r <= ld_skip_nxt;
         ld_takef_r <= ld_takef_nxt;
         ld_ovf_r <= ld_ovf_nxt;
         ld_crcb_r <= ld_crcb_nxt;
         skip_tab_r <= skip_tab_nxt;
         take_tab_r <= take_tab_nxt;
         nseg_r <= nseg_nxt;
         ref_crc_r <= ref_crc_nxt;
         dvalid_r <= dvalid_nxt;
         table_full_r <= table_full_nxt;
      end
   end

   // ==========================================
   // per-descriptor crc lanes
   logic [3:0] l_seg_r [wfm_pkg::NDESC];
   logic [3:0] l_seg_nxt [wfm_pkg::NDESC];
   logic l_tk_r [wfm_pkg::NDESC];
   logic l_tk_nxt [wfm_pkg::NDESC];
   logic [7:0] l_rem_r [wfm_pkg::NDESC];
   logic [7:0] l_rem_nxt [wfm_pkg::NDESC];
   logic [31:0] l_crc_r [wfm_pkg::NDESC];
   logic [31:0] l_crc_nxt [wfm_pkg::NDESC];
   logic [wfm_pkg::NDESC-1:0] l_act_r, l_act_nxt;
   logic [wfm_pkg::NDESC-1:0] pattern_hit_r, pattern_hit_nxt;
   logic [3:0] w_seg;
   logic w_tk;
   logic [7:0] w_rem;
   logic [31:0] w_crc;
   logic w_act;
   logic [3:0] e_seg;
   logic e_tk;
   logic [7:0] e_rem;

   always_comb
   begin
      l_seg_nxt = l_seg_r;
      l_tk_nxt = l_tk_r;
      l_rem_nxt = l_rem_r;
      l_crc_nxt = l_crc_r;
      l_act_nxt = l_act_r;
      pattern_hit_nxt = '0;
      w_seg = 4'h0;
      w_tk = 1'b0;
      w_rem = 8'h00;
      w_crc = wfm_pkg::CRC_INIT;
      w_act = 1'b0;
      e_seg = 4'h0;
      e_tk = 1'b0;
      e_rem = 8'h00;
      if (rx_valid)
      begin
         for (int d = 0; d < wfm_pkg::NDESC; d++)
         begin
            if (rx_sof)
            begin
               w_seg = 4'h0;
               w_tk = 1'b0;
               w_rem = skip_tab_r[d][0];
               w_crc = wfm_pkg::CRC_INIT;
               w_act = dvalid_r[d];
            end
            else
            begin
               w_seg = l_seg_r[d];
               w_tk = l_tk_r[d];
               w_rem = l_rem_r[d];
               w_crc = l_crc_r[d];
               w_act = l_act_r[d];
            end
            {w_seg, w_tk, w_rem} = lane_norm(w_seg, w_tk, w_rem, skip_tab_r[d], take_tab_r[d], nseg_r[d]);
            if (w_act && w_seg < nseg_r[d])
            begin
               if (w_tk)
               begin
                  w_crc = wfm_pkg::wfm_crc_byte(w_crc, rx_data);
               end
               w_rem = w_rem - 8'h01;
            end
            if (rx_eof)
            begin
               {e_seg, e_tk, e_rem} = lane_norm(w_seg, w_tk, w_rem, skip_tab_r[d], take_tab_r[d], nseg_r[d]);
               pattern_hit_nxt[d] = w_act && e_seg == nseg_r[d] && ~w_crc == ref_crc_r[d];
               w_act = 1'b0;
            end
            l_seg_nxt[d] = w_seg;
            l_tk_nxt[d] = w_tk;
            l_rem_nxt[d] = w_rem;
            l_crc_nxt[d] = w_crc;
            l_act_nxt[d] = w_act;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         l_seg_r <= '{default: '0};
         l_tk_r <= '{default: '0};
         l_rem_r <= '{default: '0};
         l_crc_r <= '{default: '0};
         l_act_r <= '0;
         pattern_hit_r <= '0;
      end
      else
      begin
         l_seg_r <= l_seg_nxt;
         l_tk_r <= l_tk_nxt;
         l_rem_r <= l_rem_nxt;
         l_crc_r <= l_crc_nxt;
         l_act_r <= l_act_nxt;
         pattern_hit_r <= pattern_hit_nxt;
      end
   end

   // ==========================================
   // repeated address block scanner
   logic [2:0] ff_run_r, ff_run_nxt;
   logic [6:0] seq_cnt_r, seq_cnt_nxt;
   logic [2:0] aidx_r, aidx_nxt;
   logic rep_done_r, rep_done_nxt;
   logic repeat_hit_r, repeat_hit_nxt;
   logic wake_event_r, wake_event_nxt;
   logic [2:0] b_ff;
   logic [6:0] b_seq;
   logic [2:0] b_aidx;
   logic b_done;

   always_comb
   begin
      ff_run_nxt = ff_run_r;
      seq_cnt_nxt = seq_cnt_r;
      aidx_nxt = aidx_r;
      rep_done_nxt = rep_done_r;
      repeat_hit_nxt = 1'b0;
      b_ff = rx_sof ? 3'h0 : ff_run_r;
      b_seq = rx_sof ? 7'h00 : seq_cnt_r;
      b_aidx = rx_sof ? 3'h0 : aidx_r;
      b_done = rx_sof ? 1'b0 : rep_done_r;
      if (rx_valid && addr_rep_en && asleep && rx_for_station)
      begin
         ff_run_nxt = (rx_data != wfm_pkg::SYNC_BYTE) ? 3'h0 :
                      (b_ff == wfm_pkg::SYNC_LEN) ? b_ff : b_ff + 3'h1;
         if (b_seq != 7'h00 && rx_data == station_addr[8 * b_aidx +: 8])
         begin
            seq_cnt_nxt = b_seq + 7'h01;
            aidx_nxt = (b_aidx == wfm_pkg::ADDR_LAST_IDX) ? 3'h0 : b_aidx + 3'h1;
         end
         else if (b_ff == wfm_pkg::SYNC_LEN && rx_data == station_addr[7:0])
         begin
            seq_cnt_nxt = 7'h01;
            aidx_nxt = 3'h1;
         end
         else
         begin
            seq_cnt_nxt = 7'h00;
            aidx_nxt = 3'h0;
         end
         rep_done_nxt = b_done;
         if (seq_cnt_nxt == wfm_pkg::SEQ_LEN)
         begin
            repeat_hit_nxt = ~b_done;
            rep_done_nxt = 1'b1;
            seq_cnt_nxt = 7'h00;
            aidx_nxt = 3'h0;
         end
      end
      else if (rx_valid)
      begin
         ff_run_nxt = 3'h0;
         seq_cnt_nxt = 7'h00;
         aidx_nxt = 3'h0;
         rep_done_nxt = b_done;
      end
      wake_event_nxt = repeat_hit_nxt | (|pattern_hit_nxt);
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ff_run_r <= 3'h0;
         seq_cnt_r <= 7'h00;
         aidx_r <= 3'h0;
         rep_done_r <= 1'b0;
         repeat_hit_r <= 1'b0;
         wake_event_r <= 1'b0;
      end
      else
      begin
         ff_run_r <= ff_run_nxt;
         seq_cnt_r <= seq_cnt_nxt;
         aidx_r <= aidx_nxt;
         rep_done_r <= rep_done_nxt;
         repeat_hit_r <= repeat_hit_nxt;
         wake_event_r <= wake_event_nxt;
      end
   end

   assign wake_event = wake_event_r;
   assign pattern_hit = pattern_hit_r;
   assign repeat_hit = repeat_hit_r;
   assign table_full = table_full_r;

endmodule

// [rtl/wfm_pkg.sv]
package wfm_pkg;
   // ==========================================
   // table geometry
   localparam int NDESC = 4;
   localparam int NSEG = 8;
   localparam int SIDX_W = 3;
   localparam int SEG_W = 4;
   localparam int DESC_W = 3;
   localparam logic [DESC_W-1:0] NDESC_L = 3'h4;
   localparam logic [SEG_W-1:0] NSEG_L = 4'h8;
   // ==========================================
   // descriptor encoding
   localparam logic [7:0] TERM_BYTE = 8'h00;
   localparam logic [3:0] EXT_NIB = 4'hf;
   localparam logic [1:0] CRC_LAST_BYTE = 2'h3;
   // ==========================================
   // repeated address block
   localparam logic [7:0] SYNC_BYTE = 8'hff;
   localparam logic [2:0] SYNC_LEN = 3'h6;
   localparam logic [2:0] ADDR_LAST_IDX = 3'h5;
   localparam logic [6:0] SEQ_LEN = 7'h60;
   // ==========================================
   // ethernet crc
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;

   typedef enum logic [2:0] {
      WFM_LD_PAIR,
      WFM_LD_EXT_SKIP,
      WFM_LD_EXT_TAKE,
      WFM_LD_CRC,
      WFM_LD_FULL
   } wfm_ld_state_t;

   typedef logic [NSEG-1:0][7:0] wfm_row_t;

   // reflected crc-32, one byte, lsb first
   function automatic logic [31:0] wfm_crc_byte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc ^ {24'h000000, data};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage
